/* File: inc/scrs_regs.vh */
`ifndef SCRS_REGS_VH
`define SCRS_REGS_VH

// register map
`define SCRS_CTRL2_ADDR       8'h2B
`define SCRS_CTRL2_RESET      8'h00
`define SCRS_ADDR_W           8
`define SCRS_DATA_W           8

// field positions
`define SCRS_SELF_TEST_BIT    7
`define SCRS_RESET_REQ_BIT    6
`define SCRS_RESERVED_BIT     5
`define SCRS_SLEEP_OSR_HI     4
`define SCRS_SLEEP_OSR_LO     3
`define SCRS_AUTO_SLEEP_BIT   2
`define SCRS_WAKE_OSR_HI      1
`define SCRS_WAKE_OSR_LO      0

// oversampling modes
`define SCRS_OSR_NORMAL       2'h0
`define SCRS_OSR_LNLP         2'h1
`define SCRS_OSR_HIRES        2'h2
`define SCRS_OSR_LOWPWR       2'h3

// sleep sample rates in mHz, non-hybrid
`define SCRS_SLP_RATE_0_MHZ   17'h0_C350
`define SCRS_SLP_RATE_1_MHZ   17'h0_30D4
`define SCRS_SLP_RATE_2_MHZ   17'h0_186A
`define SCRS_SLP_RATE_3_MHZ   17'h0_0618

// timing
`define SCRS_CLK_PERIOD_NS    50
`define SCRS_BOOT_TIME_US     500
`define SCRS_HOST_WAIT_US     1000

`endif

/* File: rtl/scrs_ctrl2.v */
`timescale 1ns/1ps
`default_nettype none
`include "scrs_regs.vh"

// Operation
// - control register at 0x2B, fields reset zero
// - self-test enable drives accelerometer stimulus
// - reset request starts boot, reloads defaults
// - reset request accepted in standby or active
// - active: drop to standby first, then reboot
// - reset request bit self-clears after boot
// - external reset pin pulse starts same boot
// - any reset also resets serial interfaces
// - sleep oversampling with sleep rate sets ratio
// - auto-sleep enable bit turns auto-sleep on
// - oversampling encoding normal, lnlp, hires, lowpower
// - wake oversampling with data rate sets ratio
// - sleep/wake switch flushes fifo, clears debounce
// - sleep rate 50/12.5/6.25/1.56 Hz, halved hybrid
module scrs_ctrl2 #(
    parameter BOOT_CYCLES = (`SCRS_BOOT_TIME_US * 1000) / `SCRS_CLK_PERIOD_NS,
    parameter CNT_W       = 16
) (
    input  wire                     sys_clk,
    input  wire                     rst,
    input  wire                     reg_wr_en,
    input  wire                     reg_rd_en,
    input  wire [`SCRS_ADDR_W-1:0]  reg_addr,
    input  wire [`SCRS_DATA_W-1:0]  reg_wdata,
    input  wire                     reset_pin,
    input  wire                     active_mode,
    input  wire                     sleep_state,
    input  wire                     hybrid_mode,
    input  wire [1:0]               sleep_rate_sel,
    input  wire [2:0]               wake_data_rate,
    output reg  [`SCRS_DATA_W-1:0]  reg_rdata_r,
    output reg                      self_test_enable_r,
    output reg                      auto_sleep_en_r,
    output reg  [1:0]               sleep_osr_mode_r,
    output reg  [1:0]               wake_osr_mode_r,
    output reg  [10:0]              oversampling_ratio_r,
    output reg  [16:0]              sleep_rate_mhz_r,
    output reg                      standby_req_r,
    output reg                      boot_reload_r,
    output reg                      serial_if_reset_r,
    output reg                      boot_busy_r,
    output reg                      fifo_flush_r,
    output reg                      debounce_clear_r
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_DROP = 2'h1;
    localparam [1:0] ST_BOOT = 2'h2;
    localparam [1:0] ST_DONE = 2'h3;

    localparam [31:0]      BOOT_LAST_W = BOOT_CYCLES - 1;
    localparam [CNT_W-1:0] BOOT_LAST   = BOOT_LAST_W[CNT_W-1:0];

    reg  [1:0]       state_r;
    reg  [1:0]       state_nxt;
    reg  [CNT_W-1:0] cnt_r;
    reg              reset_req_r;
    reg              pin_s1_r;
    reg              pin_s2_r;
    reg              pin_s3_r;
    reg              pin_lvl_r;
    reg              pin_evt_r;
    reg              sleep_prev_r;
    wire             ctrl_hit;
    wire             ctrl_wr;
    wire             sw_req;
    wire             start_req;
    wire             in_sleep;
    wire [2:0]       sleep_idx;
    wire [2:0]       osr_idx;
    wire [1:0]       osr_mode;

    // osr lookup: idx 0 = 800 Hz ... 7 = 1.5625 Hz
    function [10:0] osr_lookup;
        input [2:0] idx;
        input [1:0] mode;
        begin
            osr_lookup = 11'h002;
            case (idx)
                3'h0:
                begin
                    osr_lookup = 11'h002;
                end
                3'h1:
                begin
                    osr_lookup = (mode == `SCRS_OSR_LOWPWR) ? 11'h002 : 11'h004;
                end
                3'h2:
                begin
                    osr_lookup = (mode == `SCRS_OSR_HIRES)  ? 11'h008 :
                                 (mode == `SCRS_OSR_LOWPWR) ? 11'h002 : 11'h004;
                end
                3'h3:
                begin
                    osr_lookup = (mode == `SCRS_OSR_HIRES)  ? 11'h010 :
                                 (mode == `SCRS_OSR_LOWPWR) ? 11'h002 : 11'h004;
                end
                3'h4:
                begin
                    osr_lookup = (mode == `SCRS_OSR_HIRES)  ? 11'h020 :
                                 (mode == `SCRS_OSR_LOWPWR) ? 11'h002 : 11'h004;
                end
                3'h5:
                begin
                    case (mode)
                        `SCRS_OSR_NORMAL: osr_lookup = 11'h010;
                        `SCRS_OSR_LNLP:   osr_lookup = 11'h004;
                        `SCRS_OSR_HIRES:  osr_lookup = 11'h080;
                        default:          osr_lookup = 11'h002;
                    endcase
                end
                3'h6:
                begin
                    case (mode)
                        `SCRS_OSR_NORMAL: osr_lookup = 11'h020;
                        `SCRS_OSR_LNLP:   osr_lookup = 11'h008;
                        `SCRS_OSR_HIRES:  osr_lookup = 11'h100;
                        default:          osr_lookup = 11'h004;
                    endcase
                end
                default:
                begin
                    case (mode)
                        `SCRS_OSR_NORMAL: osr_lookup = 11'h080;
                        `SCRS_OSR_LNLP:   osr_lookup = 11'h020;
                        `SCRS_OSR_HIRES:  osr_lookup = 11'h400;
                        default:          osr_lookup = 11'h010;
                    endcase
                end
            endcase
        end
    endfunction

    assign ctrl_hit  = (reg_addr == `SCRS_CTRL2_ADDR);
    assign ctrl_wr   = reg_wr_en & ctrl_hit & (state_r == ST_IDLE) & ~serial_if_reset_r;
    assign sw_req    = ctrl_wr & reg_wdata[`SCRS_RESET_REQ_BIT];
    assign start_req = (sw_req | pin_evt_r) & (state_r == ST_IDLE);

    // reset pin synchroniser, change taken once stages 2 and 3 agree
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_s1_r  <= 1'b0;
            pin_s2_r  <= 1'b0;
            pin_s3_r  <= 1'b0;
            pin_lvl_r <= 1'b0;
            pin_evt_r <= 1'b0;
        end
        else
        begin
            pin_s1_r  <= reset_pin;
            pin_s2_r  <= pin_s1_r;
            pin_s3_r  <= pin_s2_r;
            pin_evt_r <= 1'b0;
            if (pin_s2_r == pin_s3_r)
            begin
                pin_lvl_r <= pin_s3_r;
                pin_evt_r <= pin_s3_r & ~pin_lvl_r;
            end
        end
    end

    // reset sequence
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (start_req)
                begin
                    state_nxt = active_mode ? ST_DROP : ST_BOOT;
                end
            end
            ST_DROP:
            begin
                if (!active_mode)
                begin
                    state_nxt = ST_BOOT;
                end
            end
            ST_BOOT:
            begin
                if (cnt_r == BOOT_LAST)
                begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE:
            begin
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r           <= ST_IDLE;
            cnt_r             <= {CNT_W{1'b0}};
            standby_req_r     <= 1'b0;
            boot_reload_r     <= 1'b0;
            serial_if_reset_r <= 1'b0;
            boot_busy_r       <= 1'b0;
        end
        else
        begin
            state_r       <= state_nxt;
            boot_reload_r <= 1'b0;
            if (state_nxt == ST_BOOT && state_r != ST_BOOT)
            begin
                boot_reload_r <= 1'b1;
            end
            if (state_r == ST_BOOT)
            begin
                cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            else
            begin
                cnt_r <= {CNT_W{1'b0}};
            end
            standby_req_r     <= (state_nxt != ST_IDLE);
            serial_if_reset_r <= (state_nxt != ST_IDLE);
            boot_busy_r       <= (state_nxt != ST_IDLE);
        end
    end

    // control register fields
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            self_test_enable_r <= 1'b0;
            reset_req_r        <= 1'b0;
            sleep_osr_mode_r   <= `SCRS_OSR_NORMAL;
            auto_sleep_en_r    <= 1'b0;
            wake_osr_mode_r    <= `SCRS_OSR_NORMAL;
        end
        else if (state_r == ST_DONE)
        begin
            reset_req_r <= 1'b0;
        end
        else if (start_req)
        begin
            self_test_enable_r <= 1'b0;
            reset_req_r        <= 1'b1;
            sleep_osr_mode_r   <= `SCRS_OSR_NORMAL;
            auto_sleep_en_r    <= 1'b0;
            wake_osr_mode_r    <= `SCRS_OSR_NORMAL;
        end
        else if (ctrl_wr)
        begin
            self_test_enable_r <= reg_wdata[`SCRS_SELF_TEST_BIT];
            sleep_osr_mode_r   <= reg_wdata[`SCRS_SLEEP_OSR_HI:`SCRS_SLEEP_OSR_LO];
            auto_sleep_en_r    <= reg_wdata[`SCRS_AUTO_SLEEP_BIT];
            wake_osr_mode_r    <= reg_wdata[`SCRS_WAKE_OSR_HI:`SCRS_WAKE_OSR_LO];
        end
    end

    // register read, reserved bit and other addresses read zero
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata_r <= `SCRS_CTRL2_RESET;
        end
        else if (reg_rd_en)
        begin
            if (ctrl_hit)
            begin
                reg_rdata_r <= {self_test_enable_r, reset_req_r, 1'b0, sleep_osr_mode_r,
                                auto_sleep_en_r, wake_osr_mode_r};
            end
            else
            begin
                reg_rdata_r <= 8'h00;
            end
        end
    end

    // oversampling ratio and sleep rate
    assign in_sleep  = auto_sleep_en_r & sleep_state;
    assign sleep_idx = {1'b1, sleep_rate_sel};
    assign osr_idx   = in_sleep ? sleep_idx : wake_data_rate;
    assign osr_mode  = in_sleep ? sleep_osr_mode_r : wake_osr_mode_r;

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            oversampling_ratio_r <= 11'h002;
            sleep_rate_mhz_r     <= `SCRS_SLP_RATE_0_MHZ;
        end
        else
        begin
            oversampling_ratio_r <= osr_lookup(osr_idx, osr_mode);
            case (sleep_rate_sel)
                2'h0:    sleep_rate_mhz_r <= hybrid_mode ? (`SCRS_SLP_RATE_0_MHZ >> 1)
                                                         : `SCRS_SLP_RATE_0_MHZ;
                2'h1:    sleep_rate_mhz_r <= hybrid_mode ? (`SCRS_SLP_RATE_1_MHZ >> 1)
                                                         : `SCRS_SLP_RATE_1_MHZ;
                2'h2:    sleep_rate_mhz_r <= hybrid_mode ? (`SCRS_SLP_RATE_2_MHZ >> 1)
                                                         : `SCRS_SLP_RATE_2_MHZ;
                default: sleep_rate_mhz_r <= hybrid_mode ? (`SCRS_SLP_RATE_3_MHZ >> 1)
                                                         : `SCRS_SLP_RATE_3_MHZ;
            endcase
        end
    end

    // sleep/wake transitions
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            sleep_prev_r     <= 1'b0;
            fifo_flush_r     <= 1'b0;
            debounce_clear_r <= 1'b0;
        end
        else
        begin
            sleep_prev_r     <= sleep_state;
            fifo_flush_r     <= auto_sleep_en_r & (sleep_state != sleep_prev_r);
            debounce_clear_r <= auto_sleep_en_r & (sleep_state != sleep_prev_r);
        end
    end

endmodule

`default_nettype wire

/* File: dv/scrs_ctrl2_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scrs_regs.vh"
module scrs_ctrl2_chk (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       active_mode,
    input wire logic       sleep_state,
    input wire logic [7:0] reg_rdata_r,
    input wire logic       self_test_enable_r,
    input wire logic       auto_sleep_en_r,
    input wire logic       standby_req_r,
    input wire logic       boot_reload_r,
    input wire logic       serial_if_reset_r,
    input wire logic       boot_busy_r,
    input wire logic       fifo_flush_r
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    wire hit = reg_addr == `SCRS_CTRL2_ADDR;
    wire wr_ok = reg_wr_en && hit && !boot_busy_r;
    property p_rd_unmap;
        reg_rd_en && !hit |=> reg_rdata_r == 8'h00;
    endproperty
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
    property p_rd_bits;
        reg_rd_en && hit && !boot_busy_r |=> reg_rdata_r[6:5] == 2'h0;
    endproperty
    a_rd_bits: assert property (p_rd_bits) else $error("reset or reserved bit reads one");
    property p_wr_bits;
        wr_ok && !reg_wdata[6] |=> self_test_enable_r == $past(reg_wdata[7])
            && auto_sleep_en_r == $past(reg_wdata[2]);
    endproperty
    a_wr_bits: assert property (p_wr_bits) else $error("written bits not applied");
    property p_sw_start;
        wr_ok && reg_wdata[6] |=> boot_busy_r && standby_req_r;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("reset request not started");
    property p_reload_standby;
        boot_reload_r |-> !$past(active_mode);
    endproperty
    a_reload_standby: assert property (p_reload_standby) else $error("reload while active");
    property p_standby_boot;
        $rose(boot_busy_r) && !$past(active_mode) |-> boot_reload_r;
    endproperty
    a_standby_boot: assert property (p_standby_boot) else $error("standby boot delayed");
    property p_serial;
        boot_busy_r |-> serial_if_reset_r && standby_req_r;
    endproperty
    a_serial: assert property (p_serial) else $error("serial reset not held");
    property p_boot_len;
        boot_reload_r |=> boot_busy_r [*8] ##1 !boot_busy_r;
    endproperty
    a_boot_len: assert property (p_boot_len) else $error("boot length wrong");
    property p_flush;
        auto_sleep_en_r && $changed(sleep_state) |=> fifo_flush_r;
    endproperty
    a_flush: assert property (p_flush) else $error("no flush on sleep change");
    c_boot: cover property (boot_reload_r);
    c_active: cover property (standby_req_r && active_mode);
    c_flush: cover property (fifo_flush_r);
endmodule
`default_nettype wire

/* File: dv/scrs_host.sv */
`timescale 1ns/1ps
`default_nettype none
module scrs_host #(
    parameter WAIT_CYC = 20
) (
    input wire logic        sys_clk,
    input wire logic [7:0]  reg_rdata_r,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata
);
    initial
    begin
        reg_wr_en = 0;
        reg_rd_en = 0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_wr_en = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr_en = 0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_rd_en = 1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd_en = 0;
        reg_addr = ~a;
        d = reg_rdata_r;
    endtask
    // bus kept quiet after a reset
    task quiet;
        repeat (WAIT_CYC) @(negedge sys_clk);
    endtask
endmodule
`default_nettype wire

/* File: dv/scrs_ctrl2_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "scrs_regs.vh"
module scrs_ctrl2_bench;
    logic        sys_clk = 0;
    logic        rst = 1;
    logic        reset_pin = 0;
    logic        active_mode = 0;
    logic        sleep_state = 0;
    logic        hybrid_mode = 0;
    logic [1:0]  sleep_rate_sel = 2'h0;
    logic [2:0]  wake_data_rate = 3'h0;
    logic [7:0]  rd;
    wire         reg_wr_en, reg_rd_en, self_test_enable_r, auto_sleep_en_r, standby_req_r;
    wire         boot_reload_r, serial_if_reset_r, boot_busy_r, fifo_flush_r, debounce_clear_r;
    wire [7:0]   reg_addr, reg_wdata, reg_rdata_r;
    wire [1:0]   sleep_osr_mode_r, wake_osr_mode_r;
    wire [10:0]  oversampling_ratio_r;
    wire [16:0]  sleep_rate_mhz_r;
    int          n_errors = 0;
    int          n_checks = 0;
    localparam logic [7:0] A = `SCRS_CTRL2_ADDR;
    localparam logic [43:0] R6 = {11'h004, 11'h100, 11'h008, 11'h020};
    always #25 sys_clk = ~sys_clk;
    scrs_ctrl2 #(.BOOT_CYCLES(8), .CNT_W(16)) i_scrs_ctrl2 (.sys_clk, .rst, .reg_wr_en,
        .reg_rd_en, .reg_addr, .reg_wdata, .reset_pin, .active_mode, .sleep_state, .hybrid_mode,
        .sleep_rate_sel, .wake_data_rate, .reg_rdata_r, .self_test_enable_r, .auto_sleep_en_r,
        .sleep_osr_mode_r, .wake_osr_mode_r, .oversampling_ratio_r, .sleep_rate_mhz_r,
        .standby_req_r, .boot_reload_r, .serial_if_reset_r, .boot_busy_r, .fifo_flush_r,
        .debounce_clear_r);
    scrs_host i_scrs_host (.sys_clk, .reg_rdata_r, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata);
    task chk(input string w, input logic [16:0] e, input logic [16:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] e);
        i_scrs_host.rd(a, rd);
        chk("read data", e, rd);
    endtask
    task wait_idle;
        for (int i = 0; i < 40 && boot_busy_r !== 1'b0; i++) @(negedge sys_clk);
        chk("boot busy", 0, boot_busy_r);
    endtask
    task t_fields;
        rd_chk(A, 8'h00);
        rd_chk(8'h2C, 8'h00);
        i_scrs_host.wr(A, 8'hB5);
        rd_chk(A, 8'h95);
        chk("self test", 1, self_test_enable_r);
        chk("auto sleep", 1, auto_sleep_en_r);
        for (int m = 0; m < 4; m++)
        begin
            i_scrs_host.wr(A, {3'h0, m[1:0], 1'b0, m[1:0]});
            chk("sleep mode", m, sleep_osr_mode_r);
            chk("wake mode", m, wake_osr_mode_r);
        end
        chk("self test off", 0, self_test_enable_r);
        chk("auto sleep off", 0, auto_sleep_en_r);
    endtask
    task t_osr;
        i_scrs_host.wr(A, 8'h16);
        wake_data_rate = 3'h7;
        repeat (2) @(negedge sys_clk);
        chk("wake ratio slow", 11'h400, oversampling_ratio_r);
        wake_data_rate = 3'h0;
        repeat (2) @(negedge sys_clk);
        chk("wake ratio fast", 11'h002, oversampling_ratio_r);
        wake_data_rate = 3'h6;
        for (int m = 0; m < 4; m++)
        begin
            i_scrs_host.wr(A, {6'h05, m[1:0]});
            @(negedge sys_clk);
            chk("wake ratio mode", R6[m*11 +: 11], oversampling_ratio_r);
        end
        sleep_rate_sel = 2'h3;
        sleep_state = 1;
        @(negedge sys_clk);
        chk("fifo flush", 1, fifo_flush_r);
        chk("debounce clear", 1, debounce_clear_r);
        @(negedge sys_clk);
        chk("sleep ratio", 11'h400, oversampling_ratio_r);
        chk("sleep rate slow", 17'h0_0618, sleep_rate_mhz_r);
        sleep_rate_sel = 2'h0;
        hybrid_mode = 1;
        repeat (2) @(negedge sys_clk);
        chk("sleep rate", 17'h0_61A8, sleep_rate_mhz_r);
        sleep_state = 0;
        hybrid_mode = 0;
    endtask
    task t_boot_standby;
        i_scrs_host.wr(A, 8'h85);
        i_scrs_host.wr(A, 8'h40);
        chk("standby req", 1, standby_req_r);
        chk("serial reset", 1, serial_if_reset_r);
        i_scrs_host.wr(A, 8'h80);
        rd_chk(A, 8'h40);
        wait_idle();
        rd_chk(A, 8'h00);
    endtask
    task t_boot_active;
        i_scrs_host.wr(A, 8'h04);
        active_mode = 1;
        i_scrs_host.wr(A, 8'h40);
        chk("standby req", 1, standby_req_r);
        repeat (3)
        begin
            @(negedge sys_clk);
            chk("early reload", 0, boot_reload_r);
        end
        active_mode = 0;
        wait_idle();
        rd_chk(A, 8'h00);
    endtask
    task t_pin;
        i_scrs_host.wr(A, 8'h84);
        reset_pin = 1;
        repeat (2) @(negedge sys_clk);
        reset_pin = 0;
        for (int i = 0; i < 10 && boot_busy_r !== 1'b1; i++) @(negedge sys_clk);
        chk("pin boot", 1, boot_busy_r);
        chk("serial reset", 1, serial_if_reset_r);
        wait_idle();
        i_scrs_host.quiet();
        rd_chk(A, 8'h00);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(negedge sys_clk);
        rst = 0;
        t_fields();
        t_osr();
        t_boot_standby();
        t_boot_active();
        t_pin();
        wrap_up();
    end
    initial
    begin
        #(50 * 5000);
        n_errors++;
        wrap_up();
    end
endmodule
bind scrs_ctrl2 scrs_ctrl2_chk i_scrs_ctrl2_chk (.sys_clk, .rst, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wdata, .active_mode, .sleep_state, .reg_rdata_r, .self_test_enable_r,
    .auto_sleep_en_r, .standby_req_r, .boot_reload_r, .serial_if_reset_r, .boot_busy_r,
    .fifo_flush_r);
`default_nettype wire
